/* rtl/bptp_port.v */
// Purpose: Five memory-mapped bidirectional ports with tone pair on port B
// Assumes: CPU strobes come from sys_clk logic; pads are asynchronous
// Notes:   Pad inputs pass two flip-flops before the read mux sees them
`include "bptp_regs.vh"

// Contract
// RQ1 - Port data latches sit at addresses 12H, 14H, 16H, 18H, 1EH.
// RQ2 - Inputs are not latched; reads sample pads on the read strobe; code reads pads through a two-flop synchroniser, two clocks late.
// RQ3 - Output latch holds its value until software rewrites it.
// RQ4 - Per-line direction bit: 1 is input, 0 drives output.
// RQ5 - Reads return pad for input lines, latch for output lines.
// RQ6 - Direction registers sit at 13H, 15H, 17H, 19H, 1FH.
// RQ7 - Output lines are always push-pull, never open drain.
// RQ8 - After reset every line is non-driving.
// RQ9 - Bit set, clear, complement read whole port then write back.
// RQ10 - Port A lines with wake option can wake the halted device.
// RQ11 - Upper five port G bits read zero and ignore writes.
// RQ12 - Optional weak pull-up per line, chosen at build time; code has one option bit per port.
// RQ13 - Tone option drives divider signal and complement on B0 and B1.
// RQ14 - Only port B bit 0 data gates the tone; 0 forces low.
// RQ15 - Port G line 0 pin also feeds the active-low external interrupt.
// RQ16 - Port G lines 1, 2 work only in internal-RC-with-I/O oscillator mode.
// RQ17 - Software should make unused lines outputs to avoid floating inputs.
// RQ18 - Tone divider signal derives from timer 0 overflow.
// RQ19 - Direction reads return last write; each bit controls its line.
module bptp_port #(
  parameter [7:0] PORT_A_WAKE_OPT = 8'h00,
  parameter [4:0] PULLUP_OPT      = 5'b0_0000,
  parameter       TONE_OPT        = 0,
  parameter       OSC_RC_IO_OPT   = 0
) (
  input  wire       sys_clk,
  input  wire       rstn,
  input  wire [7:0] cpu_addr,
  input  wire [7:0] cpu_wdata,
  input  wire       cpu_wr,
  input  wire       cpu_rd,
  output reg  [7:0] cpu_rdata,
  output wire       cpu_hit,
  input  wire       halted,
  output wire       wake_req,
  input  wire       tone_divider_signal,
  output wire       ext_int_n,
  input  wire [7:0] port_a_in,
  output wire [7:0] port_a_out,
  output wire [7:0] port_a_oe,
  output wire [7:0] port_a_pullup,
  input  wire [7:0] port_b_in,
  output wire [7:0] port_b_out,
  output wire [7:0] port_b_oe,
  output wire [7:0] port_b_pullup,
  input  wire [7:0] port_c_in,
  output wire [7:0] port_c_out,
  output wire [7:0] port_c_oe,
  output wire [7:0] port_c_pullup,
  input  wire [7:0] port_d_in,
  output wire [7:0] port_d_out,
  output wire [7:0] port_d_oe,
  output wire [7:0] port_d_pullup,
  input  wire [2:0] port_g_in,
  output wire [2:0] port_g_out,
  output wire [2:0] port_g_oe,
  output wire [2:0] port_g_pullup
);

  // ****************************************
  // Storage
  // ****************************************
  reg  [7:0] data_latch [0:4];
  reg  [7:0] dir_reg    [0:4];
  reg  [7:0] pad_meta   [0:4];
  reg  [7:0] pad_sync   [0:4];
  reg  [7:0] next_rdata;
  reg        next_hit;
  wire [7:0] pad_raw    [0:4];
  wire [7:0] impl_mask  [0:4];
  wire [7:0] g_mask;
  integer    i;

  // Lines 1, 2 of port G lost to the oscillator outside RC+I/O mode
  assign g_mask = (OSC_RC_IO_OPT != 0) ? `BPTP_PORT_G_MASK : 8'h01; // RQ16

  assign pad_raw[0] = port_a_in;
  assign pad_raw[1] = port_b_in;
  assign pad_raw[2] = port_c_in;
  assign pad_raw[3] = port_d_in;
  assign pad_raw[4] = {5'b0_0000, port_g_in};
  assign impl_mask[0] = 8'hFF;
  assign impl_mask[1] = 8'hFF;
  assign impl_mask[2] = 8'hFF;
  assign impl_mask[3] = 8'hFF;
  assign impl_mask[4] = g_mask; // RQ11

  // ****************************************
  // Address decode
  // ****************************************
  function [2:0] port_index;
    input [7:0] addr;
    begin
      case ({addr[7:1], 1'b0})
        `BPTP_ADDR_PORT_A_DATA: port_index = 3'd0;
        `BPTP_ADDR_PORT_B_DATA: port_index = 3'd1;
        `BPTP_ADDR_PORT_C_DATA: port_index = 3'd2;
        `BPTP_ADDR_PORT_D_DATA: port_index = 3'd3;
        `BPTP_ADDR_PORT_G_DATA: port_index = 3'd4;
        default:                port_index = 3'd7;
      endcase
    end
  endfunction

  wire [2:0] sel_port = port_index(cpu_addr); // RQ1 RQ6
  wire       sel_dir  = cpu_addr[0];
  wire       sel_ok   = (sel_port != 3'd7);

  // ****************************************
  // Registers and pad synchroniser
  // ****************************************
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      for (i = 0; i < 5; i = i + 1) begin
        data_latch[i] <= `BPTP_DATA_RESET;
        dir_reg[i]    <= `BPTP_DIR_RESET; // RQ8
        pad_meta[i]   <= 8'h00;
        pad_sync[i]   <= 8'h00;
      end
    end else begin
      for (i = 0; i < 5; i = i + 1) begin
        pad_meta[i] <= pad_raw[i];
        pad_sync[i] <= pad_meta[i];
      end
      // Latch only changes on a write; read-modify-write lands here too
      if (cpu_wr && sel_ok) begin
        if (sel_dir)
          dir_reg[sel_port] <= cpu_wdata & impl_mask[sel_port]; // RQ4 RQ19 RQ11
        else
          data_latch[sel_port] <= cpu_wdata & impl_mask[sel_port]; // RQ3 RQ9 RQ11
      end
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  always @* begin
    next_rdata = 8'h00;
    next_hit   = 1'b0;
    if (cpu_rd && sel_ok) begin
      next_hit = 1'b1;
      if (sel_dir)
        next_rdata = dir_reg[sel_port] & impl_mask[sel_port]; // RQ19
      else
        next_rdata = ((dir_reg[sel_port] & pad_sync[sel_port]) |
                      (~dir_reg[sel_port] & data_latch[sel_port]))
                     & impl_mask[sel_port]; // RQ2 RQ5 RQ9 RQ11
    end
  end

  // Registered data; hit is the combinational handshake
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn)
      cpu_rdata <= 8'h00;
    else
      cpu_rdata <= next_rdata;
  end
  assign cpu_hit = next_hit;

  // ****************************************
  // Pad drive
  // ****************************************
  // Push-pull only: oe is the inverse of direction, gated by g_mask on port G
  wire tone_on = (TONE_OPT != 0);
  wire tone_b0 = data_latch[1][`BPTP_TONE_LINE] & tone_divider_signal; // RQ14 RQ18
  wire tone_b1 = data_latch[1][`BPTP_TONE_LINE] & ~tone_divider_signal; // RQ14

  assign port_a_out = data_latch[0];
  assign port_a_oe  = ~dir_reg[0]; // RQ7
  assign port_b_out = tone_on ? {data_latch[1][7:2], tone_b1, tone_b0}
                              : data_latch[1]; // RQ13
  assign port_b_oe  = ~dir_reg[1]; // RQ7 RQ13
  assign port_c_out = data_latch[2];
  assign port_c_oe  = ~dir_reg[2];
  assign port_d_out = data_latch[3];
  assign port_d_oe  = ~dir_reg[3];
  assign port_g_out = data_latch[4][2:0];
  assign port_g_oe  = ~dir_reg[4][2:0] & g_mask[2:0]; // RQ16

  // Build-time pull-ups, one option bit per port
  assign port_a_pullup = {8{PULLUP_OPT[0]}}; // RQ12
  assign port_b_pullup = {8{PULLUP_OPT[1]}};
  assign port_c_pullup = {8{PULLUP_OPT[2]}};
  assign port_d_pullup = {8{PULLUP_OPT[3]}};
  assign port_g_pullup = {3{PULLUP_OPT[4]}} & g_mask[2:0]; // RQ16

  // ****************************************
  // Interrupt pin and wake-up
  // ****************************************
  // Synchronised level; the interrupt logic does its own edge detect
  assign ext_int_n = pad_sync[4][`BPTP_INT_LINE]; // RQ15
  // Wake on any low on a selected input line; pull-up holds it idle high
  assign wake_req  = halted & |(~pad_sync[0] & dir_reg[0] & PORT_A_WAKE_OPT); // RQ10

endmodule // bptp_port

/* rtl/bptp_regs.vh */
// Purpose: Addresses, widths and reset values of the I/O port block
// Assumes: Byte-wide data memory addresses on the CPU side
// Notes:   Data latch at even address, direction register one above
`ifndef BPTP_REGS_VH
`define BPTP_REGS_VH
`define BPTP_ADDR_PORT_A_DATA 8'h12
`define BPTP_ADDR_PORT_A_DIR  8'h13
`define BPTP_ADDR_PORT_B_DATA 8'h14
`define BPTP_ADDR_PORT_B_DIR  8'h15
`define BPTP_ADDR_PORT_C_DATA 8'h16
`define BPTP_ADDR_PORT_C_DIR  8'h17
`define BPTP_ADDR_PORT_D_DATA 8'h18
`define BPTP_ADDR_PORT_D_DIR  8'h19
`define BPTP_ADDR_PORT_G_DATA 8'h1E
`define BPTP_ADDR_PORT_G_DIR  8'h1F
`define BPTP_DIR_RESET        8'hFF
`define BPTP_DATA_RESET       8'hFF
`define BPTP_PORT_G_MASK      8'h07
`define BPTP_TONE_LINE        0
`define BPTP_TONE_INV_LINE    1
`define BPTP_INT_LINE         0
`endif

/* test/bptp_pads.sv */
// Purpose: Board and pad model for all 35 port lines
// Assumes: Bench supplies board drive per line
// Notes:   Released line without pull-up flips each cycle
module bptp_pads #(parameter int W = 35) (
  input  wire logic         sys_clk,
  input  wire logic [W-1:0] oe,
  input  wire logic [W-1:0] out,
  input  wire logic [W-1:0] ext_en,
  input  wire logic [W-1:0] ext_val,
  input  wire logic [W-1:0] pu,
  output logic      [W-1:0] pad
);
  logic [W-1:0] last;
  always_ff @(posedge sys_clk) last <= pad;
  // Pin drive wins over board drive: push-pull only
  always_comb for (int i = 0; i < W; i++)
    pad[i] = oe[i] ? out[i] : ext_en[i] ? ext_val[i] : pu[i] | ~last[i];
endmodule // bptp_pads

/* test/bptp_port_asserts.sv */
// Purpose: Port timing and mapping checks
// Assumes: One clock domain
// Notes:   Tone checks only with tone option
module bptp_chk #(parameter TONE_OPT = 0) (
  input wire       sys_clk,
  input wire       rstn,
  input wire [7:0] cpu_addr,
  input wire [7:0] cpu_wdata,
  input wire       cpu_wr,
  input wire       cpu_rd,
  input wire [7:0] cpu_rdata,
  input wire       cpu_hit,
  input wire       halted,
  input wire       wake_req,
  input wire       tone_divider_signal,
  input wire [7:0] port_a_out,
  input wire [7:0] port_a_oe,
  input wire [7:0] port_b_out
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  sequence s_rd(a); cpu_rd && cpu_addr == a; endsequence
  sequence s_wr(a); cpu_wr && cpu_addr == a; endsequence
  a_reset_idle: assert property ($rose(rstn) |-> port_a_oe == 8'h00)
    else $error("oe set after reset");
  a_rdata_idle: assert property (!$past(cpu_rd) |-> cpu_rdata == 8'h00)
    else $error("rdata not idle");
  a_hit_map: assert property (cpu_hit == (cpu_rd && cpu_addr inside
    {[8'h12:8'h19], 8'h1E, 8'h1F})) else $error("hit wrong");
  a_dir_write: assert property (s_wr(8'h13) |=> port_a_oe == ~$past(cpu_wdata))
    else $error("oe not from dir");
  a_data_hold: assert property (!(cpu_wr && cpu_addr == 8'h12) |=> $stable(port_a_out))
    else $error("latch moved");
  a_g_upper: assert property (s_rd(8'h1E) |=> cpu_rdata[7:3] == 5'h00)
    else $error("g upper set");
  a_read_latch: assert property (s_rd(8'h12) ##0 port_a_oe == 8'hFF
    |=> cpu_rdata == $past(port_a_out)) else $error("read not latch");
  a_tone_pair: assert property (TONE_OPT != 0 && port_b_out[1]
    |-> !port_b_out[0] && !tone_divider_signal) else $error("tone pair");
  a_wake_halt: assert property (wake_req |-> halted) else $error("wake awake");
endmodule // bptp_chk
bind bptp_port bptp_chk #(.TONE_OPT(TONE_OPT)) chk_u (.sys_clk, .rstn, .cpu_addr,
  .cpu_wdata, .cpu_wr, .cpu_rd, .cpu_rdata, .cpu_hit, .halted, .wake_req,
  .tone_divider_signal, .port_a_out, .port_a_oe, .port_b_out);

/* test/bptp_port_tb.sv */
// Purpose: Self-checking bench for the port block
// Assumes: Board drives every input line
// Notes:   Random stimulus from a fixed LFSR seed
module bptp_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk = 0, rstn = 0, cpu_wr = 0, cpu_rd = 0, halted = 0, tone = 0;
  logic [7:0]  cpu_addr = 0, cpu_wdata = 0, cpu_rdata, d, lat [5], dir [5];
  logic        cpu_hit, wake_req, ext_int_n;
  logic [39:0] ext_en = '1, ext_val = '0, oe, out, pu, pad;
  logic [15:0] rnd = 16'h6654;
  int          miscompares = 0, total_checks = 0, cyc = 0, p;
  localparam logic [7:0] BASE [5] = '{8'h12, 8'h14, 8'h16, 8'h18, 8'h1E};
  bptp_port #(.PORT_A_WAKE_OPT(8'hFF), .PULLUP_OPT(5'h15), .TONE_OPT(1), .OSC_RC_IO_OPT(1))
  dut_u (.sys_clk, .rstn, .cpu_addr, .cpu_wdata, .cpu_wr, .cpu_rd, .cpu_rdata, .cpu_hit,
    .halted, .wake_req, .tone_divider_signal(tone), .ext_int_n,
    .port_a_in(pad[7:0]), .port_a_out(out[7:0]), .port_a_oe(oe[7:0]), .port_a_pullup(pu[7:0]),
    .port_b_in(pad[15:8]), .port_b_out(out[15:8]), .port_b_oe(oe[15:8]),
    .port_b_pullup(pu[15:8]), .port_c_in(pad[23:16]), .port_c_out(out[23:16]),
    .port_c_oe(oe[23:16]), .port_c_pullup(pu[23:16]), .port_d_in(pad[31:24]),
    .port_d_out(out[31:24]), .port_d_oe(oe[31:24]), .port_d_pullup(pu[31:24]),
    .port_g_in(pad[34:32]), .port_g_out(out[34:32]), .port_g_oe(oe[34:32]),
    .port_g_pullup(pu[34:32]));
  bptp_pads pads_u (.sys_clk, .oe(oe[34:0]), .out(out[34:0]), .ext_en(ext_en[34:0]),
    .ext_val(ext_val[34:0]), .pu(pu[34:0]), .pad(pad[34:0]));
  function automatic logic [15:0] lfsr(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [7:0] msk(int q);
    return q == 4 ? 8'h07 : 8'hFF;
  endfunction
  task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] v);
    @(posedge sys_clk);
    cpu_wr <= 1;
    cpu_addr <= a;
    cpu_wdata <= v;
    @(posedge sys_clk);
    cpu_wr <= 0;
  endtask
  // Strobe held for the taking edge only; data one cycle later
  task automatic rd(logic [7:0] a);
    @(posedge sys_clk);
    cpu_rd <= 1;
    cpu_addr <= a;
    #1 chk("hit", {7'h00, cpu_hit}, {7'h00, a inside {[8'h12:8'h19], 8'h1E, 8'h1F}});
    @(posedge sys_clk);
    cpu_rd <= 0;
    #1 d = cpu_rdata;
  endtask
  task automatic end_of_test();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial forever #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      miscompares++;
      end_of_test();
    end
  end
  initial begin
    repeat (10) @(posedge sys_clk);
    rstn <= 1;
    chk("oe", oe[7:0] | oe[15:8] | oe[23:16] | oe[31:24], 8'h00);
    for (p = 0; p < 5; p++) begin
      rd(BASE[p] + 8'h01);
      chk("dir", d, msk(p));
    end
    chk("pullup", pu[7:0] & pu[23:16], 8'hFF);
    chk("pullup", pu[15:8] | pu[31:24] | {5'h00, pu[34:32]}, 8'h07);
    // Port A all outputs so the latch readback assertion sees a case
    wr(8'h13, 8'h00);
    wr(8'h12, 8'hA5);
    rd(8'h12);
    chk("latch", d, 8'hA5);
    $display("reset test done");
    repeat (40) begin
      p = rnd % 5;
      rnd = lfsr(rnd);
      wr(BASE[p] + 8'h01, rnd[7:0]);
      dir[p] = rnd[7:0] & msk(p);
      rnd = lfsr(rnd);
      wr(BASE[p], rnd[7:0]);
      lat[p] = rnd[7:0] & msk(p);
      rnd = lfsr(rnd);
      ext_val <= {rnd, rnd, rnd[7:0]};
      repeat (3) @(posedge sys_clk);
      chk("oe", oe[p*8 +: 8] & msk(p), ~dir[p] & msk(p));
      if (p == 4 && dir[4][0]) chk("int", {7'h00, ext_int_n}, {7'h00, ext_val[32]});
      rd(BASE[p]);
      chk("data", d, (dir[p] & ext_val[p*8 +: 8] | ~dir[p] & lat[p]) & msk(p));
      wr(BASE[p], d | 8'h01);
      #1 chk("rmw", out[p*8 +: 8] & ~dir[p] & msk(p) & 8'hFC, d & ~dir[p] & 8'hFC);
    end
    rd(8'h1A);
    chk("unmapped", d, 8'h00);
    $display("random test done");
    wr(8'h15, 8'hFC);
    for (int k = 0; k < 4; k++) begin
      wr(8'h14, {7'h00, k[1]});
      tone <= k[0];
      @(posedge sys_clk);
      #1 chk("tone", {6'h00, out[9:8]}, {6'h00, k[1] & ~k[0], k[1] & k[0]});
    end
    wr(8'h13, 8'hFF);
    halted <= 1;
    ext_val <= '1;
    repeat (3) @(posedge sys_clk);
    ext_val[3] <= 0;
    chk("wake", {7'h00, wake_req}, 8'h00);
    repeat (3) @(posedge sys_clk);
    #1 chk("wake", {7'h00, wake_req}, 8'h01);
    @(posedge sys_clk);
    halted <= 0;
    @(posedge sys_clk);
    #1 chk("wake", {7'h00, wake_req}, 8'h00);
    // Unused port G lines parked as outputs by software
    wr(8'h1F, 8'h00);
    #1 chk("unused", {5'h00, oe[34:32]}, 8'h07);
    $display("tone and wake test done");
    end_of_test();
  end
endmodule // bptp_port_tb
